// ---- hdl/mux_master_reset_config.sv ----
// Master reset, revision readout and configuration register bank.
// What this block does
// - Soft reset clears registers, lines send ones.
// - Soft reset ORed with hardware reset pin.
// - Flush bit rising edge empties receive FIFOs.
// - Second-order resync bit edge resyncs framers.
// - High-speed resync bit edge resyncs framer.
// - Upper byte reads revision, ignores writes.
// - Zero-substitution coders bypassed when bit set.
// - Unchannelized bit picks framer or multiplexer data.
// - Unchannelized mode skips overhead framer positions.
// - T3 C bits from framer when parity on.
// - Auto mode updates counters each second.
// - Manual update on bit or pin edge.
// - Manual bit ignored in auto mode.
// - NRZ mode drives minus rail low.
// - Detect lost transmit clock, optional fallback.
// - Frame pulse direction selected by bit.
// - Shared low-rate clocks replace individual ones.
// - Payload strobes level or gapped clock.
// - Loop timing applies to every low-rate port.
// - Invert bit inverts line transmit clock.
// - One-second tick timed from receive line clock.
`timescale 1ns/1ps
`include "mux_cfg_defines.svh"
module mux_master_reset_config #(
	parameter int SECOND_CYCLES = `SECOND_LINE_CYCLES
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic hwRst_n,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Pins from the line and framer side.
	input wire logic line_rx_clock,
	input wire logic framer_tx_clock,
	input wire logic count_update_pin,
	// Configuration and event outputs.
	output mux_cfg_pkg::cfg_t cfgOut,
	output mux_cfg_pkg::pulses_t pulseOut,
	output logic deviceReset,
	output logic sendAllOnes,
	output logic tx_clock_lost_flag,
	output logic txClockFallback,
	output logic tx_frame_pulse_oe_n
);
	logic [3:0] resetReg_ff;
	logic [11:0] cfgOne_ff;
	logic cfgTwo_ff;
	logic [1:0] hwRstSync_ff;
	logic devRst;
	logic [2:0] rxClkSync_ff;
	logic [2:0] txClkSync_ff;
	logic [1:0] pinSync_ff;
	logic pinPrev_ff;
	logic [3:0] edgePrev_ff;
	logic [31:0] secCount_ff;
	logic [7:0] lossCount_ff;
	logic tickFlag_ff;
	mux_cfg_pkg::bus_state_t busState_ff;
	logic access;
	logic [15:0] rdWord;
	logic rxEdge;
	logic secondWrap;
	logic lossHit;
	logic manualEdge;
	logic pinEdge;
	logic statusRead;
	logic [3:0] holdCount_ff;

	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction

	// A write needs the request, the byte lane and the exact word address.
	function automatic logic regHit(input logic acc, input logic wr, input logic lane,
		input logic [7:0] adr, input logic [7:0] target);
		return acc & wr & lane & (adr == target);
	endfunction

	// The mirror lags the registers by one cycle, which software cannot observe.
	function automatic mux_cfg_pkg::cfg_t cfgMap(input logic [11:0] one, input logic two);
		mux_cfg_pkg::cfg_t m;
		m.zeroSubOff = one[`BIT_ZERO_SUB_OFF];
		m.unchannelized = one[`BIT_UNCHAN];
		m.cbitParity = one[`BIT_CBIT_PARITY];
		m.autoDefeat = one[`BIT_AUTO_DEFEAT];
		m.nrzLine = one[`BIT_NRZ_LINE];
		m.clkFallback = one[`BIT_CLK_FALLBACK];
		m.framePulseIn = one[`BIT_FRAME_DIR];
		m.txShared = one[`BIT_TX_SHARED];
		m.rxShared = one[`BIT_RX_SHARED];
		m.strobeGapped = one[`BIT_STROBE_STYLE];
		m.loopTiming = one[`BIT_LOOP_TIMING];
		m.txClkInvert = two;
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers; first stage feeds only the second.
	// The reset pin is asynchronous, so it is synchronised like any other pin.
	always_ff @(posedge ref_clk) begin
		hwRstSync_ff <= {hwRstSync_ff[0], ~hwRst_n};
	end

	always_ff @(posedge ref_clk) begin
		rxClkSync_ff <= {rxClkSync_ff[1:0], line_rx_clock};
	end

	always_ff @(posedge ref_clk) begin
		txClkSync_ff <= {txClkSync_ff[1:0], framer_tx_clock};
	end

	always_ff @(posedge ref_clk) begin
		pinSync_ff <= {pinSync_ff[0], count_update_pin};
		pinPrev_ff <= pinSync_ff[1];
	end

	// A soft reset clears its own bit in the next cycle, so it lasts one cycle.
	assign devRst = sys_rst | hwRstSync_ff[1] | resetReg_ff[`BIT_SOFT_RESET];

	// Event decodes; rxEdge, secondWrap and lossHit are each used by more than one process.
	assign rxEdge = rise(rxClkSync_ff[1], rxClkSync_ff[2]);
	assign secondWrap = rxEdge & (secCount_ff == 32'(SECOND_CYCLES - 1));
	assign lossHit = (lossCount_ff == 8'(`CLOCK_LOSS_CYCLES));
	assign manualEdge = rise(cfgOne_ff[`BIT_MANUAL_UPDATE], edgePrev_ff[3]);
	assign pinEdge = rise(pinSync_ff[1], pinPrev_ff);
	assign statusRead = access & ~we_i & (adr_i == `IDX_STATUS);

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone handshake: ack one cycle after the request, then one idle cycle.
	assign access = cyc_i & stb_i & (busState_ff == mux_cfg_pkg::BUS_IDLE);

	// The idle cycle after each ack keeps a held request from being taken twice.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			busState_ff <= mux_cfg_pkg::BUS_IDLE;
		end else begin
			unique case (busState_ff)
				mux_cfg_pkg::BUS_IDLE: begin
					if (cyc_i & stb_i) begin
						busState_ff <= mux_cfg_pkg::BUS_ACK;
					end
				end
				mux_cfg_pkg::BUS_ACK: busState_ff <= mux_cfg_pkg::BUS_GAP;
				mux_cfg_pkg::BUS_GAP: busState_ff <= mux_cfg_pkg::BUS_IDLE;
				default: busState_ff <= mux_cfg_pkg::BUS_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= access;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register writes; soft reset returns all to zero.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			resetReg_ff <= 4'(`REG_RESET_VALUE);
		end else if (regHit(access, we_i, sel_i[0], adr_i, `IDX_RESET_REV)) begin
			resetReg_ff <= dat_i[3:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			cfgOne_ff <= 12'(`REG_RESET_VALUE);
		end else begin
			if (regHit(access, we_i, sel_i[0], adr_i, `IDX_CONFIG_ONE)) begin
				cfgOne_ff[7:0] <= dat_i[7:0];
			end
			if (regHit(access, we_i, sel_i[1], adr_i, `IDX_CONFIG_ONE)) begin
				cfgOne_ff[11:8] <= dat_i[11:8];
			end
		end
	end

	// Only the clock-invert bit of the second register exists here.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			cfgTwo_ff <= 1'b0;
		end else if (regHit(access, we_i, sel_i[0], adr_i, `IDX_CONFIG_TWO)) begin
			cfgTwo_ff <= dat_i[`BIT_TXCLK_INVERT];
		end
	end

	always_comb begin
		rdWord = 16'h0000;
		unique case (adr_i)
			`IDX_RESET_REV: rdWord = {`REVISION_ID, 4'h0, resetReg_ff};
			`IDX_CONFIG_ONE: rdWord = {4'h0, cfgOne_ff};
			`IDX_CONFIG_TWO: rdWord = {15'h0000, cfgTwo_ff};
			`IDX_STATUS: rdWord = {14'h0000, tx_clock_lost_flag, tickFlag_ff};
			default: rdWord = 16'h0000;
		endcase
	end

	// Read data is zero outside the ack cycle, so stale values never leak.
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dat_o <= 32'h00000000;
		end else begin
			dat_o <= (access & ~we_i) ? {16'h0000, rdWord} : 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// One-second tick counted on receive line clock edges from any start point.
	// A tick beats a status read in the same cycle, so no boundary is lost.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			secCount_ff <= 32'h00000000;
		end else if (rxEdge) begin
			secCount_ff <= secondWrap ? 32'h00000000 : secCount_ff + 32'h00000001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			tickFlag_ff <= 1'b0;
		end else if (secondWrap) begin
			tickFlag_ff <= 1'b1;
		end else if (statusRead) begin
			tickFlag_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Transmit clock watchdog: no edge for a while means the clock is lost.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			lossCount_ff <= 8'h00;
		end else if (txClkSync_ff[1] != txClkSync_ff[2]) begin
			lossCount_ff <= 8'h00;
		end else if (lossCount_ff != 8'(`CLOCK_LOSS_CYCLES)) begin
			lossCount_ff <= lossCount_ff + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Edge-triggered controls; each fires once per rising edge of its bit.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			edgePrev_ff <= 4'h0;
		end else begin
			edgePrev_ff <= {cfgOne_ff[`BIT_MANUAL_UPDATE], resetReg_ff[3:1]};
		end
	end

	// Manual and pin edges only count while automatic update is defeated.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			pulseOut <= '0;
		end else begin
			pulseOut.fifoFlush <= rise(resetReg_ff[`BIT_FIFO_FLUSH], edgePrev_ff[0]);
			pulseOut.secondResync <= rise(resetReg_ff[`BIT_SECOND_RESYNC], edgePrev_ff[1]);
			pulseOut.hsResync <= rise(resetReg_ff[`BIT_HS_RESYNC], edgePrev_ff[2]);
			pulseOut.countUpdate <= cfgOne_ff[`BIT_AUTO_DEFEAT] ?
				(manualEdge | pinEdge) :
				secondWrap;
			pulseOut.secondTick <= tickFlag_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration mirror toward the datapath.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			cfgOut <= '0;
		end else begin
			cfgOut <= cfgMap(cfgOne_ff, cfgTwo_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset and clock-loss outputs.
	// A soft reset is one cycle inside, but the line side sees it for 11 cycles, at least 100ns.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			holdCount_ff <= 4'(`SOFT_RESET_MIN_CYC);
		end else if (holdCount_ff != 4'h0) begin
			holdCount_ff <= holdCount_ff - 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			deviceReset <= 1'b1;
		end else begin
			deviceReset <= (holdCount_ff != 4'h0);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			sendAllOnes <= 1'b1;
		end else begin
			sendAllOnes <= (holdCount_ff != 4'h0);
		end
	end

	// Real-time flag: it follows the watchdog and needs no clear.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			tx_clock_lost_flag <= 1'b0;
		end else begin
			tx_clock_lost_flag <= lossHit;
		end
	end

	// Fallback follows the loss only while software allows it.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			txClockFallback <= 1'b0;
		end else begin
			txClockFallback <= lossHit & cfgOne_ff[`BIT_CLK_FALLBACK];
		end
	end

	// Low enable means the block drives the frame pulse pin.
	always_ff @(posedge ref_clk) begin
		if (devRst) begin
			tx_frame_pulse_oe_n <= 1'b0;
		end else begin
			tx_frame_pulse_oe_n <= cfgOne_ff[`BIT_FRAME_DIR];
		end
	end
endmodule // mux_master_reset_config

// ---- hdl/mux_cfg_defines.svh ----
// Register offsets, field positions, reset values and timing counts of the master config bank.
`ifndef MUX_CFG_DEFINES_SVH
`define MUX_CFG_DEFINES_SVH
`define IDX_RESET_REV 8'h00
`define IDX_CONFIG_ONE 8'h02
`define IDX_CONFIG_TWO 8'h04
`define IDX_STATUS 8'h06
`define BIT_SOFT_RESET 0
`define BIT_FIFO_FLUSH 1
`define BIT_SECOND_RESYNC 2
`define BIT_HS_RESYNC 3
`define BIT_ZERO_SUB_OFF 0
`define BIT_UNCHAN 1
`define BIT_CBIT_PARITY 2
`define BIT_AUTO_DEFEAT 3
`define BIT_MANUAL_UPDATE 4
`define BIT_NRZ_LINE 5
`define BIT_CLK_FALLBACK 6
`define BIT_FRAME_DIR 7
`define BIT_TX_SHARED 8
`define BIT_RX_SHARED 9
`define BIT_STROBE_STYLE 10
`define BIT_LOOP_TIMING 11
`define BIT_TXCLK_INVERT 0
`define MASK_RESET_REV 16'h000f
`define MASK_CONFIG_ONE 16'h0fff
`define MASK_CONFIG_TWO 16'h0001
`define REG_RESET_VALUE 16'h0000
`define REVISION_ID 8'h5a
`define SOFT_RESET_MIN_NS 100
`define SOFT_RESET_MIN_CYC ((`SOFT_RESET_MIN_NS + 9) / 10)
`define CLK_PERIOD_NS 10
`define SECOND_LINE_CYCLES 44736000
`define CLOCK_LOSS_CYCLES 64
`endif

// ---- hdl/mux_cfg_pkg.sv ----
// Types shared by the master reset and configuration bank.
package mux_cfg_pkg;
	typedef struct packed {
		logic zeroSubOff;
		logic unchannelized;
		logic cbitParity;
		logic autoDefeat;
		logic nrzLine;
		logic clkFallback;
		logic framePulseIn;
		logic txShared;
		logic rxShared;
		logic strobeGapped;
		logic loopTiming;
		logic txClkInvert;
	} cfg_t;
	typedef struct packed {
		logic fifoFlush;
		logic secondResync;
		logic hsResync;
		logic countUpdate;
		logic secondTick;
	} pulses_t;
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK = 2'b01,
		BUS_GAP = 2'b10
	} bus_state_t;
endpackage

// ---- test/mux_cfg_sva.sv ----
// Port checks for the master reset and configuration bank.
`timescale 1ns/1ps
`include "mux_cfg_defines.svh"
module mux_cfg_sva #(
	parameter int SECOND_CYCLES = 20
) (
	// Clock and resets.
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic hwRst_n,
	// Bus.
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Block side.
	input wire logic framer_tx_clock,
	input wire mux_cfg_pkg::cfg_t cfgOut,
	input wire mux_cfg_pkg::pulses_t pulseOut,
	input wire logic deviceReset,
	input wire logic sendAllOnes,
	input wire logic tx_clock_lost_flag,
	input wire logic tx_frame_pulse_oe_n
);
	logic [7:0] idleCnt_ff;
	logic lastClk_ff;
	// Margin over the 64-cycle threshold covers the pin synchroniser.
	always_ff @(posedge ref_clk) begin
		lastClk_ff <= framer_tx_clock;
		if (sys_rst || !hwRst_n || framer_tx_clock != lastClk_ff) begin
			idleCnt_ff <= 8'h00;
		end else if (idleCnt_ff != 8'hff) begin
			idleCnt_ff <= idleCnt_ff + 8'h01;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_ack_latency: assert property ($rose(stb_i) |=> ack_o)
		else $error("ack late");
	a_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack too long");
	a_hw_reset: assert property (
		!hwRst_n [*6] |-> deviceReset && sendAllOnes && cfgOut == '0)
		else $error("pin reset not applied");
	a_flush_pulse: assert property (pulseOut.fifoFlush |=> !pulseOut.fifoFlush)
		else $error("flush pulse too long");
	a_resync_pulse: assert property (pulseOut.hsResync |=> !pulseOut.hsResync)
		else $error("resync pulse too long");
	a_rev_read: assert property (
		ack_o && !we_i && adr_i == 8'h00 |-> dat_o[31:8] == {16'h0000, `REVISION_ID})
		else $error("revision wrong");
	a_unmapped_zero: assert property (
		ack_o && !we_i && adr_i > 8'h06 |-> dat_o == 32'h00000000)
		else $error("unmapped read not zero");
	a_cfg_spare: assert property (
		ack_o && !we_i && adr_i == 8'h02 |-> dat_o[31:12] == 20'h00000)
		else $error("spare bits not zero");
	a_clock_lost: assert property (idleCnt_ff >= 8'd80 |-> tx_clock_lost_flag)
		else $error("lost clock not flagged");
	a_pulse_dir: assert property (
		ack_o && !we_i && adr_i == 8'h02 |-> tx_frame_pulse_oe_n == dat_o[`BIT_FRAME_DIR])
		else $error("frame pulse direction wrong");
	c_flush: cover property (pulseOut.fifoFlush);
	c_lost: cover property (tx_clock_lost_flag);
	c_status: cover property (ack_o && !we_i && adr_i == 8'h06);
endmodule // mux_cfg_sva
bind mux_master_reset_config mux_cfg_sva #(.SECOND_CYCLES(SECOND_CYCLES)) chk (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .hwRst_n(hwRst_n), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .framer_tx_clock(framer_tx_clock),
	.cfgOut(cfgOut), .pulseOut(pulseOut), .deviceReset(deviceReset),
	.sendAllOnes(sendAllOnes), .tx_clock_lost_flag(tx_clock_lost_flag),
	.tx_frame_pulse_oe_n(tx_frame_pulse_oe_n));

// ---- test/line_side_model.sv ----
// Behavioural line interface: receive clock, framer transmit clock and update pin.
`timescale 1ns/1ps
module line_side_model (
	// Bench controls.
	input wire logic txRun,
	input wire logic updReq,
	// Pins toward the block.
	output logic line_rx_clock,
	output logic framer_tx_clock,
	output logic count_update_pin
);
	// Both clocks are slower than half the sampling rate, so no level is missed.
	initial begin
		line_rx_clock = 1'b0;
		framer_tx_clock = 1'b0;
	end
	always #25 line_rx_clock = ~line_rx_clock;
	always #35 framer_tx_clock = txRun ? ~framer_tx_clock : framer_tx_clock;
	assign count_update_pin = updReq;
endmodule // line_side_model

// ---- test/mux_master_reset_config_tb_top.sv ----
// Self-checking bench for the master reset and configuration bank.
`timescale 1ns/1ps
`include "mux_cfg_defines.svh"
module mux_master_reset_config_tb_top;
	logic ref_clk, sys_rst, hwRst_n, cyc, stb, we, txRun, updReq, ack_o, lrc, ftc, cup;
	logic deviceReset, sendAllOnes, lost, fallback;
	logic [7:0] adr;
	logic [15:0] rd;
	logic [31:0] wdat, dat_o;
	logic [11:0] c;
	mux_cfg_pkg::cfg_t cfgOut;
	mux_cfg_pkg::pulses_t pulseOut;
	int errors, checked, flushN, syncN, hsN, updN, rstN, i, k;
	mux_master_reset_config #(.SECOND_CYCLES(20)) uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.hwRst_n(hwRst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h3),
		.dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .line_rx_clock(lrc), .framer_tx_clock(ftc),
		.count_update_pin(cup), .cfgOut(cfgOut), .pulseOut(pulseOut), .deviceReset(deviceReset),
		.sendAllOnes(sendAllOnes), .tx_clock_lost_flag(lost), .txClockFallback(fallback),
		.tx_frame_pulse_oe_n());
	line_side_model far (.txRun(txRun), .updReq(updReq), .line_rx_clock(lrc),
		.framer_tx_clock(ftc), .count_update_pin(cup));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		flushN <= flushN + (pulseOut.fifoFlush === 1'b1);
		syncN <= syncN + (pulseOut.secondResync === 1'b1);
		hsN <= hsN + (pulseOut.hsResync === 1'b1);
		updN <= updN + (pulseOut.countUpdate === 1'b1);
		rstN <= rstN + (sendAllOnes === 1'b1);
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {16'h0000, d};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		rd = dat_o[15:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20) errors++;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
		wb(1'b0, a, 16'h0000);
		chk(rd, exp);
	endtask
	task tally_and_finish;
		$display("checked=%0d errors=%0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{sys_rst, hwRst_n, txRun} = 3'b111;
		{cyc, stb, we, updReq, adr, wdat} = '0;
		{errors, checked, flushN, syncN, hsN, updN, rstN} = '0;
		repeat (10) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdchk(8'h00, {`REVISION_ID, 8'h00});
		rdchk(8'h04, 16'h0000);
		rdchk(8'h10, 16'h0000);
		for (i = 0; i < 12; i++) begin
			c = 12'h001 << i;
			wb(1'b1, 8'h02, 16'h8000 | 16'(c));
			rdchk(8'h02, 16'(c));
			chk(cfgOut, {c[0], c[1], c[2], c[3], c[5], c[6], c[7], c[8], c[9], c[10], c[11], 1'b0});
		end
		wb(1'b1, 8'h04, 16'hffff);
		rdchk(8'h04, 16'h0001);
		chk(cfgOut, 12'h003);
		k = rstN;
		wb(1'b1, 8'h00, 16'h0001);
		repeat (10) @(posedge ref_clk);
		wb(1'b1, 8'h00, 16'h0000);
		rdchk(8'h04, 16'h0000);
		chk(rstN > k, 1'b1);
		wb(1'b1, 8'h00, 16'hfffe);
		rdchk(8'h00, {`REVISION_ID, 8'h0e});
		wb(1'b1, 8'h00, 16'h000e);
		wb(1'b1, 8'h00, 16'h0000);
		wb(1'b1, 8'h00, 16'h000e);
		repeat (3) @(posedge ref_clk);
		chk(flushN, 2);
		chk(syncN, 2);
		chk(hsN, 2);
		wb(1'b1, 8'h02, 16'h0000);
		repeat (300) @(posedge ref_clk);
		chk(updN > 1, 1'b1);
		chk(pulseOut.secondTick, 1'b1);
		rdchk(8'h06, 16'h0001);
		wb(1'b1, 8'h02, 16'h0008);
		repeat (5) @(posedge ref_clk);
		k = updN;
		repeat (300) @(posedge ref_clk);
		chk(updN, k);
		wb(1'b1, 8'h02, 16'h0018);
		wb(1'b1, 8'h02, 16'h0018);
		updReq <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk(updN, k + 2);
		wb(1'b1, 8'h02, 16'h0040);
		txRun <= 1'b0;
		repeat (100) @(posedge ref_clk);
		chk({lost, fallback}, 2'b11);
		wb(1'b1, 8'h02, 16'h0021);
		txRun <= 1'b1;
		repeat (20) @(posedge ref_clk);
		chk({lost, fallback}, 2'b00);
		hwRst_n <= 1'b0;
		repeat (8) @(posedge ref_clk);
		hwRst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdchk(8'h02, 16'h0000);
		tally_and_finish;
	end
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		tally_and_finish;
	end
endmodule // mux_master_reset_config_tb_top
